// >>> cld_pkg.sv
// Package for the cold load detector: register map, field layouts, reset values, timing.
// Assumes a 40 MHz clock and an AHB-Lite master with 32-bit single word transfers.
package cld_pkg;

  // ****************************************
  // Clock and processing cycle
  // ****************************************
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned TICK_US         = 5000;                          // Processing cycle, 5 ms
  localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1000000) * TICK_US;  // 200000 clocks
  localparam int unsigned TICK_STEP_MS    = 5;                             // Timer setting step
  localparam int unsigned HYST_NUM        = 97;                            // Drop-out ratio in percent
  localparam int unsigned HYST_DEN        = 100;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // Bit 0 enable, bit 1 counter clear
  localparam logic [7:0] OFS_ILOW   = 8'h04;  // Threshold, 0.01 x In per lsb
  localparam logic [7:0] OFS_IHIGH  = 8'h08;
  localparam logic [7:0] OFS_IOVER  = 8'h0c;
  localparam logic [7:0] OFS_TSET   = 8'h10;  // Ticks of 5 ms
  localparam logic [7:0] OFS_TMAX   = 8'h14;
  localparam logic [7:0] OFS_TMIN   = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;  // Condition code and outputs
  localparam logic [7:0] OFS_COUNT  = 8'h20;  // Cumulative event counter
  localparam logic [7:0] OFS_LOGSEL = 8'h24;  // Log entry index to read
  localparam logic [7:0] OFS_LOGRD  = 8'h28;  // Selected log entry
  localparam logic [7:0] OFS_LOGCNT = 8'h2c;  // Write pointer and fill level

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_CLR_BIT = 1;

  // ****************************************
  // Reset values (thresholds in 0.01 x In, times in ticks)
  // ****************************************
  localparam logic [15:0] RST_ILOW  = 16'h0014;  // 0.20 x In
  localparam logic [15:0] RST_IHIGH = 16'h0078;  // 1.20 x In
  localparam logic [15:0] RST_IOVER = 16'h00c8;  // 2.00 x In
  localparam logic [19:0] RST_TSET  = 20'h007d0; // 10.000 s
  localparam logic [19:0] RST_TMAX  = 20'h01770; // 30.000 s
  localparam logic [19:0] RST_TMIN  = 20'h00008; // 0.040 s
  localparam int unsigned LOG_DEPTH = 12;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    CC_NORMAL, CC_LOW, CC_OVER, CC_ACTIVE, CC_BLOCKED
  } cld_cond_t;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
  } cld_phases_t;

  typedef struct packed {
    logic [15:0] low;
    logic [15:0] high;
    logic [15:0] over;
  } cld_thr_t;

  typedef struct packed {
    logic [1:0]  kind;   // 1 activated, 2 blocked
    logic [29:0] stamp;  // Processing-cycle count at the event
  } cld_log_t;

endpackage

// >>> cld_detector.sv
// Cold load detector: threshold comparison, pick-up timers, blocking, condition code, log.
// Assumes phase magnitudes arrive from measurement logic on the same clock, and the
// block input from another domain (it is synchronised here).
//
// Summary of operation
// - Compare fundamental-frequency magnitudes of three phases
// - High and overcurrent drop out at 97 percent of threshold; low picks up there
// - One common threshold for all phases
// - Low condition when all phases below low
// - High condition when all phases above high
// - Any phase over overcurrent releases output immediately
// - Sample block input once per cycle
// - Unblocked pick-up asserts active, runs timers
// - Blocked pick-up gives blocked indication only
// - Block during active resets output, runs release
// - Low must persist for start delay, restarts
// - Maximum timer limits high current duration
// - Minimum timer sets shortest active time, reclaim
// - High current counts toward maximum, then releases
// - Return between thresholds ends start-up, min extends
// - Zero start delay activates in same cycle
// - No inrush holds output for minimum time
// - Inrush during minimum starts the maximum timer
// - Five-state condition code exposed
// - Resettable counter of active and blocked events
// - Rolling log of last twelve events
module cld_detector #(
  // Clocks per processing tick; a bench may shorten it to keep runs brief
  parameter int unsigned TICK_LEN = cld_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                  MCLK_IN,
  input  wire logic                  RST_IN,
  // AHB-Lite slave
  input  wire logic                  HSEL_IN,
  input  wire logic [7:0]            HADDR_IN,
  input  wire logic [1:0]            HTRANS_IN,
  input  wire logic                  HWRITE_IN,
  input  wire logic [2:0]            HSIZE_IN,
  input  wire logic [31:0]           HWDATA_IN,
  input  wire logic                  HREADY_IN,
  output logic      [31:0]           HRDATA_OUT,
  output logic                       HREADYOUT_OUT,
  output logic                       HRESP_OUT,
  // Phase magnitudes and blocking
  input  wire cld_pkg::cld_phases_t  PHASE_MAG_IN,
  input  wire logic                  BLOCK_IN,
  // Detector outputs
  output logic                       COLD_LOAD_ACTIVE_OUT,
  output logic                       BLOCKED_OUT,
  output logic [2:0]                 DETECTOR_CONDITION_CODE_OUT
);

  // ****************************************
  // Registers
  // ****************************************
  logic                 en_r;
  cld_pkg::cld_thr_t    thr_r;
  logic [19:0]          tset_r, tmax_r, tmin_r;
  logic [15:0]          count_r;
  logic [3:0]           logsel_r, logwp_r, logfill_r;
  cld_pkg::cld_log_t    log_mem [cld_pkg::LOG_DEPTH];
  logic [29:0]          stamp_r;
  logic [17:0]          div_r;
  logic                 blk_s1_r, blk_s2_r, blk_r;
  logic                 low_r, high_r, over_r;
  logic                 active_r, blocked_r, inrush_r;
  logic [19:0]          tset_cnt_r, tmax_cnt_r, tmin_cnt_r;
  cld_pkg::cld_cond_t   cond_r;

  // Hysteresis: drop-out level is 97 % of the setting, rounded down
  function automatic logic [15:0] drop_lvl(input logic [15:0] thr);
    logic [31:0] p;
    p = 32'(thr) * 32'(cld_pkg::HYST_NUM);
    return 16'(p / 32'(cld_pkg::HYST_DEN));
  endfunction

  // ****************************************
  // Processing tick
  // ****************************************
  // A 5 ms tick drives all timers, so settings are whole ticks
  wire tick = (div_r == 18'(TICK_LEN - 1));

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      div_r   <= '0;
      stamp_r <= '0;
    end else begin
      div_r   <= tick ? '0 : div_r + 18'h1;
      stamp_r <= tick ? stamp_r + 30'h1 : stamp_r;
    end
  end

  // Block input: two-flop synchroniser, then held for the whole cycle
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      blk_s1_r <= 1'b0;
      blk_s2_r <= 1'b0;
      blk_r    <= 1'b0;
    end else begin
      blk_s1_r <= BLOCK_IN;
      blk_s2_r <= blk_s1_r;
      if (tick) begin
        blk_r <= blk_s2_r;
      end
    end
  end

  // ****************************************
  // Threshold comparison with hysteresis
  // ****************************************
  // One common threshold per level is applied to all three phases
  wire [15:0] ma = PHASE_MAG_IN.a;
  wire [15:0] mb = PHASE_MAG_IN.b;
  wire [15:0] mc = PHASE_MAG_IN.c;
  wire [15:0] low_drop  = drop_lvl(thr_r.low);
  wire [15:0] high_drop = drop_lvl(thr_r.high);
  wire [15:0] over_drop = drop_lvl(thr_r.over);
  // Low picks up with all below; drops out once any rises past the setting
  wire low_now  = low_r ? (ma <= thr_r.low && mb <= thr_r.low && mc <= thr_r.low)
                        : (ma < low_drop && mb < low_drop && mc < low_drop);
  // High needs all phases above; drops out when any falls to 97 %
  wire high_now = high_r ? (ma > high_drop && mb > high_drop && mc > high_drop)
                         : (ma > thr_r.high && mb > thr_r.high && mc > thr_r.high);
  // Overcurrent: any single phase
  wire over_now = over_r ? (ma > over_drop || mb > over_drop || mc > over_drop)
                         : (ma > thr_r.over || mb > thr_r.over || mc > thr_r.over);

  // ****************************************
  // Timer and activation logic
  // ****************************************
  // Start timer: low must hold continuously; zero delay picks up at once
  wire tset_done = low_now && (tset_r == 20'h0 || tset_cnt_r + 20'h1 >= tset_r);
  wire pickup    = !active_r && !blocked_r && tset_done && tick;
  wire tmin_done = tmin_cnt_r >= tmin_r;
  wire tmax_done = tmax_cnt_r + 20'h1 >= tmax_r;
  // Release causes while active, the overcurrent one being immediate
  wire rel_over  = active_r && over_now;
  wire rel_block = active_r && blk_r;
  wire rel_max   = active_r && tick && high_now && tmax_done;
  wire rel_norm  = active_r && tick && !high_now && tmin_done;
  wire release_c = rel_over || rel_block || rel_max || rel_norm;
  wire ev_act    = pickup && !blk_r;
  wire ev_blk    = pickup && blk_r;

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      low_r  <= 1'b0;
      high_r <= 1'b0;
      over_r <= 1'b0;
    end else begin
      low_r  <= low_now;
      high_r <= high_now;
      over_r <= over_now;
    end
  end

  // Start timer restarts whenever low breaks
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN || !en_r || !low_now || active_r || blocked_r) begin
      tset_cnt_r <= '0;
    end else if (tick && !tset_done) begin
      tset_cnt_r <= tset_cnt_r + 20'h1;
    end
  end

  // Min timer runs from activation; max timer runs while high after an inrush
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN || !active_r) begin
      tmin_cnt_r <= '0;
      tmax_cnt_r <= '0;
      inrush_r   <= 1'b0;
    end else if (tick) begin
      if (!tmin_done) begin
        tmin_cnt_r <= tmin_cnt_r + 20'h1;
      end
      if (high_now) begin
        inrush_r   <= 1'b1;
        tmax_cnt_r <= tmax_cnt_r + 20'h1;
      end
    end
  end

  // Active and blocked flags; blocked clears at a tick once the low condition ends or the block sample drops
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN || !en_r) begin
      active_r  <= 1'b0;
      blocked_r <= 1'b0;
    end else begin
      if (ev_act) begin
        active_r <= 1'b1;
      end else if (release_c) begin
        active_r <= 1'b0;
      end
      if (ev_blk) begin
        blocked_r <= 1'b1;
      end else if (tick && (!low_now || !blk_r)) begin
        blocked_r <= 1'b0;
      end
    end
  end

  // Condition code, priority: blocked, active, overcurrent, low, normal
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      cond_r <= cld_pkg::CC_NORMAL;
    end else if (blocked_r) begin
      cond_r <= cld_pkg::CC_BLOCKED;
    end else if (active_r) begin
      cond_r <= cld_pkg::CC_ACTIVE;
    end else if (over_r) begin
      cond_r <= cld_pkg::CC_OVER;
    end else if (low_r) begin
      cond_r <= cld_pkg::CC_LOW;
    end else begin
      cond_r <= cld_pkg::CC_NORMAL;
    end
  end

  assign COLD_LOAD_ACTIVE_OUT        = active_r;
  assign BLOCKED_OUT                 = blocked_r;
  assign DETECTOR_CONDITION_CODE_OUT = cond_r;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Zero wait states: every access completes in its data phase with OKAY
  logic       ph_wr_r, ph_rd_r;
  logic [7:0] ph_addr_r;
  wire        ahb_go = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  wire        wr     = ph_wr_r;
  wire        ev_any = ev_act || ev_blk;
  wire        clr    = wr && ph_addr_r == cld_pkg::OFS_CTRL && HWDATA_IN[cld_pkg::CTRL_CLR_BIT];

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      ph_wr_r   <= 1'b0;
      ph_rd_r   <= 1'b0;
      ph_addr_r <= '0;
    end else begin
      ph_wr_r   <= ahb_go && HWRITE_IN;
      ph_rd_r   <= ahb_go && !HWRITE_IN;
      ph_addr_r <= ahb_go ? HADDR_IN : ph_addr_r;
    end
  end

  // Setting registers
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      en_r     <= 1'b1;
      thr_r    <= '{cld_pkg::RST_ILOW, cld_pkg::RST_IHIGH, cld_pkg::RST_IOVER};
      tset_r   <= cld_pkg::RST_TSET;
      tmax_r   <= cld_pkg::RST_TMAX;
      tmin_r   <= cld_pkg::RST_TMIN;
      logsel_r <= '0;
    end else if (wr) begin
      case (ph_addr_r)
        cld_pkg::OFS_CTRL:   en_r      <= HWDATA_IN[cld_pkg::CTRL_EN_BIT];
        cld_pkg::OFS_ILOW:   thr_r.low <= HWDATA_IN[15:0];
        cld_pkg::OFS_IHIGH:  thr_r.high <= HWDATA_IN[15:0];
        cld_pkg::OFS_IOVER:  thr_r.over <= HWDATA_IN[15:0];
        cld_pkg::OFS_TSET:   tset_r    <= HWDATA_IN[19:0];
        cld_pkg::OFS_TMAX:   tmax_r    <= HWDATA_IN[19:0];
        cld_pkg::OFS_TMIN:   tmin_r    <= HWDATA_IN[19:0];
        cld_pkg::OFS_LOGSEL: logsel_r  <= HWDATA_IN[3:0];
        default: ;
      endcase
    end
  end

  // Counter: a new event in the clearing cycle counts from zero, so it is not lost
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      count_r <= '0;
    end else if (clr) begin
      count_r <= ev_any ? 16'h1 : 16'h0;
    end else if (ev_any) begin
      count_r <= count_r + 16'h1;
    end
  end

  // Rolling log overwrites the oldest entry once twelve are held
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      logwp_r   <= '0;
      logfill_r <= '0;
    end else if (ev_any) begin
      log_mem[logwp_r] <= '{ev_act ? 2'h1 : 2'h2, stamp_r};
      logwp_r   <= (logwp_r == 4'(cld_pkg::LOG_DEPTH - 1)) ? 4'h0 : logwp_r + 4'h1;
      logfill_r <= (logfill_r == 4'(cld_pkg::LOG_DEPTH)) ? logfill_r : logfill_r + 4'h1;
    end
  end

  // Read mux; unmapped addresses read as zero
  wire [31:0] status_w = {24'h0, 1'b0, blocked_r, active_r, 2'b00, cond_r};
  wire [31:0] log_w    = (logsel_r < 4'(cld_pkg::LOG_DEPTH)) ? 32'(log_mem[logsel_r]) : 32'h0;
  logic [31:0] rd_w;
  always_comb begin
    case (ph_addr_r)
      cld_pkg::OFS_CTRL:   rd_w = {31'h0, en_r};
      cld_pkg::OFS_ILOW:   rd_w = {16'h0, thr_r.low};
      cld_pkg::OFS_IHIGH:  rd_w = {16'h0, thr_r.high};
      cld_pkg::OFS_IOVER:  rd_w = {16'h0, thr_r.over};
      cld_pkg::OFS_TSET:   rd_w = {12'h0, tset_r};
      cld_pkg::OFS_TMAX:   rd_w = {12'h0, tmax_r};
      cld_pkg::OFS_TMIN:   rd_w = {12'h0, tmin_r};
      cld_pkg::OFS_STATUS: rd_w = status_w;
      cld_pkg::OFS_COUNT:  rd_w = {16'h0, count_r};
      cld_pkg::OFS_LOGSEL: rd_w = {28'h0, logsel_r};
      cld_pkg::OFS_LOGRD:  rd_w = log_w;
      cld_pkg::OFS_LOGCNT: rd_w = {24'h0, logfill_r, logwp_r};
      default:             rd_w = 32'h0;
    endcase
  end

  assign HRDATA_OUT    = ph_rd_r ? rd_w : 32'h0;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_overcurrent;
    active_r && over_now;
  endsequence

  over_release_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    s_overcurrent |=> !active_r) else $error("Active held through overcurrent");
  block_sample_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    !tick |=> $stable(blk_r)) else $error("Block sample changed mid cycle");
  act_pickup_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    ev_act && en_r |=> active_r && !blocked_r) else $error("Pick-up did not activate");
  blk_pickup_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    ev_blk && en_r |=> blocked_r && !active_r) else $error("Blocked pick-up activated");
  block_reset_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    active_r && blk_r |=> !active_r) else $error("Block did not reset output");
  start_delay_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    $rose(active_r) && tset_r != 20'h0 |-> $past(tset_cnt_r) + 20'h1 >= tset_r)
    else $error("Activated before start delay");
  min_time_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    $fell(active_r) && !$past(over_now) && !$past(blk_r) && !$past(high_now) && en_r
    |-> $past(tmin_cnt_r) >= tmin_r) else $error("Released before minimum time");
  counter_step_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    ev_any && !clr |=> count_r == $past(count_r) + 16'h1) else $error("Counter missed event");
  cond_code_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    blocked_r |=> cond_r == cld_pkg::CC_BLOCKED) else $error("Condition code wrong");

  // Pick-up at a tick with no start delay, and the end of an inrush that lasts too long
  sequence s_zero_delay_pickup;
    en_r && tick && tset_r == 20'h0 && low_now && !active_r && !blocked_r && !blk_r;
  endsequence
  sequence s_max_expiry;
    active_r && tick && high_now && tmax_done;
  endsequence

  zero_delay_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    s_zero_delay_pickup |=> active_r) else $error("No pick-up with zero start delay");
  max_release_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    s_max_expiry |=> !active_r) else $error("Active held past maximum time");
  // Inrush while active must start the maximum timer, unless something releases first
  inrush_start_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    active_r && tick && high_now && !tmax_done && !over_now && !blk_r && en_r
    |=> inrush_r && tmax_cnt_r != 20'h0) else $error("Inrush did not start maximum timer");
  cond_active_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    !blocked_r && active_r |=> cond_r == cld_pkg::CC_ACTIVE) else $error("Active code wrong");
  tick_wrap_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    tick |=> div_r == 18'h0) else $error("Tick divider did not wrap");
  low_pickup_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    ev_any |-> ma <= thr_r.low && mb <= thr_r.low && mc <= thr_r.low)
    else $error("Pick-up without all phases low");
  blocked_clear_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    blocked_r && tick && !blk_r |=> !blocked_r) else $error("Blocked flag stuck");

endmodule

// >>> cld_meas_model.sv
// Far-side model: phase magnitude measurement and the blocking matrix source.
// Assumes the bench sets the requested magnitudes and block level just after a rising edge.
module cld_meas_model (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // Requested values from the bench
  input  wire logic [15:0]           a_in,
  input  wire logic [15:0]           b_in,
  input  wire logic [15:0]           c_in,
  input  wire logic                  blk_in,
  input  wire logic                  slow_in,
  // Values seen by the detector
  output cld_pkg::cld_phases_t       mag_out,
  output logic                       block_out
);
  timeunit 1ns;
  timeprecision 100ps;

  cld_pkg::cld_phases_t stage_r;

  // Fundamental magnitudes, one per phase; slow mode adds a filter stage of latency
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stage_r   <= '0;
      mag_out   <= '0;
      block_out <= 1'b0;
    end else begin
      stage_r   <= '{a: a_in, b: b_in, c: c_in};
      mag_out   <= slow_in ? stage_r : '{a: a_in, b: b_in, c: c_in};
      block_out <= blk_in;  // Bench raises it ticks ahead of any delay expiry
    end
  end
endmodule

// >>> tb_top.sv
// Testbench for the cold load detector: register tasks and tick-timed current scenarios.
// Assumes a shortened tick that restarts at reset release, so stimulus is applied mid-tick.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Signals
  // ****************************************
  localparam int          TK  = 200;       // Shortened tick keeps the run brief
  localparam logic [15:0] NRM = 16'h0032;  // 0.50 x In, between low and high
  localparam logic [15:0] LOW = 16'h000a;  // 0.10 x In
  logic                 mclk   = 1'b0;
  logic                 rst    = 1'b1;
  logic                 hsel   = 1'b0;
  logic [7:0]           haddr  = 8'h00;
  logic [1:0]           htrans = 2'h0;
  logic                 hwrite = 1'b0;
  logic [31:0]          hwdata = 32'h0;
  logic                 hready;
  logic [31:0]          hrdata;
  logic                 hresp;
  logic [15:0]          pa = NRM, pb = NRM, pc = NRM;
  logic                 blk = 1'b0;
  logic                 slow = 1'b0;
  cld_pkg::cld_phases_t mag;
  logic                 blk_w, act, bld;
  logic [2:0]           code;
  logic [31:0]          rd;
  int                   cyc = 0;
  int                   err_total = 0;
  int                   total_checks = 0;
  localparam logic [7:0]  RA [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h30};
  localparam logic [31:0] RV [9] = '{32'h1, 32'h14, 32'h78, 32'hc8, 32'h7d0, 32'h1770, 32'h8, 32'h0, 32'h0};

  // Clock of 25 ns; cycle count since reset release also drives the timeout
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= rst ? 0 : cyc + 1;
    if (cyc == 40 * TK) begin
      err_total++;
      end_of_test();
    end
  end

  cld_meas_model meas (.clk_in(mclk), .rst_in(rst), .a_in(pa), .b_in(pb), .c_in(pc),
                       .blk_in(blk), .slow_in(slow), .mag_out(mag), .block_out(blk_w));

  cld_detector #(.TICK_LEN(TK)) dut (.MCLK_IN(mclk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .PHASE_MAG_IN(mag), .BLOCK_IN(blk_w), .COLD_LOAD_ACTIVE_OUT(act), .BLOCKED_OUT(bld),
    .DETECTOR_CONDITION_CODE_OUT(code));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One single AHB transfer; ready, response and read data are taken at the rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Pins and the status word must agree
  task automatic st(input logic a, input logic b, input logic [2:0] c);
    chk({27'h0, bld, act, code}, {27'h0, b, a, c});
    rd_chk(cld_pkg::OFS_STATUS, {25'h0, b, a, 2'b00, c});
  endtask

  task automatic ph(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    pa <= a;
    pb <= b;
    pc <= c;
  endtask

  // Moves to the middle of the next tick n times, so bus traffic cannot drift the phase
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge mclk);
      while ((cyc % TK) != TK / 2) @(posedge mclk);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    // Reset values, then an unmapped place that must stay zero
    for (int i = 0; i < 9; i++) begin
      rd_chk(RA[i], RV[i]);
    end
    bus(1'b1, 8'h30, 32'h5a5a);
    rd_chk(8'h30, 32'h0);
    // Short timers keep the run to a handful of shortened 200-clock ticks
    bus(1'b1, cld_pkg::OFS_TSET, 32'h0);
    bus(1'b1, cld_pkg::OFS_TMIN, 32'h2);
    bus(1'b1, cld_pkg::OFS_TMAX, 32'h3);
    rd_chk(cld_pkg::OFS_TMIN, 32'h2);
    while ((cyc % TK) != TK / 2) @(posedge mclk);
    // One phase above low: no pick-up
    ph(LOW, LOW, 16'h0019);
    tk(1);
    st(1'b0, 1'b0, cld_pkg::CC_NORMAL);
    // All low with zero start delay, then no inrush
    ph(LOW, LOW, LOW);
    tk(1);
    st(1'b1, 1'b0, cld_pkg::CC_ACTIVE);
    ph(NRM, NRM, NRM);
    tk(1);
    st(1'b1, 1'b0, cld_pkg::CC_ACTIVE);
    tk(2);
    st(1'b0, 1'b0, cld_pkg::CC_NORMAL);
    // Inrush during the minimum time runs to the maximum time
    ph(LOW, LOW, LOW);
    tk(1);
    ph(16'h0096, 16'h0096, 16'h0096);
    tk(2);
    chk({31'h0, act}, 32'h1);
    tk(2);
    chk({31'h0, act}, 32'h0);
    // Overcurrent on one phase releases at once; slow measurement path
    slow <= 1'b1;
    ph(LOW, LOW, LOW);
    tk(1);
    chk({31'h0, act}, 32'h1);
    ph(NRM, NRM, 16'h00c9);
    repeat (6) @(posedge mclk);
    chk({31'h0, act}, 32'h0);
    tk(1);
    chk({29'h0, code}, cld_pkg::CC_OVER);
    ph(NRM, NRM, 16'h00c4);
    tk(1);
    chk({29'h0, code}, cld_pkg::CC_OVER);
    ph(NRM, NRM, NRM);
    tk(1);
    chk({29'h0, code}, cld_pkg::CC_NORMAL);
    slow <= 1'b0;
    // Pick-up while blocked gives only the blocked indication
    blk <= 1'b1;
    tk(1);
    ph(LOW, LOW, LOW);
    tk(1);
    st(1'b0, 1'b1, cld_pkg::CC_BLOCKED);
    blk <= 1'b0;
    ph(NRM, NRM, NRM);
    tk(1);
    st(1'b0, 1'b0, cld_pkg::CC_NORMAL);
    // Block arriving while active: seen only at the next tick, then releases
    ph(LOW, LOW, LOW);
    tk(1);
    ph(NRM, NRM, NRM);
    blk <= 1'b1;
    repeat (10) @(posedge mclk);
    chk({31'h0, act}, 32'h1);
    tk(1);
    chk({31'h0, act}, 32'h0);
    blk <= 1'b0;
    // Five events: four activations and one blocked pick-up
    rd_chk(cld_pkg::OFS_COUNT, 32'h5);
    bus(1'b0, cld_pkg::OFS_LOGCNT, 32'h0);
    chk(rd & 32'hf0, 32'h50);
    chk(rd & 32'h0f, 32'h05);
    // Oldest entry is an activation, the fourth the blocked pick-up
    bus(1'b1, cld_pkg::OFS_LOGSEL, 32'h0);
    bus(1'b0, cld_pkg::OFS_LOGRD, 32'h0);
    chk(rd & 32'hc0000000, 32'h40000000);
    bus(1'b1, cld_pkg::OFS_LOGSEL, 32'h3);
    bus(1'b0, cld_pkg::OFS_LOGRD, 32'h0);
    chk(rd & 32'hc0000000, 32'h80000000);
    bus(1'b1, cld_pkg::OFS_CTRL, 32'h3);
    rd_chk(cld_pkg::OFS_COUNT, 32'h0);
    // Start delay of two ticks restarts when low breaks
    bus(1'b1, cld_pkg::OFS_TSET, 32'h2);
    ph(LOW, LOW, LOW);
    tk(1);
    chk({31'h0, act}, 32'h0);
    ph(NRM, NRM, NRM);
    tk(1);
    ph(LOW, LOW, LOW);
    tk(1);
    chk({31'h0, act}, 32'h0);
    tk(1);
    chk({31'h0, act}, 32'h1);
    rd_chk(cld_pkg::OFS_COUNT, 32'h1);
    // Disabling drops the output; the code then shows low current
    bus(1'b1, cld_pkg::OFS_CTRL, 32'h0);
    repeat (3) @(posedge mclk);
    st(1'b0, 1'b0, cld_pkg::CC_LOW);
    end_of_test();
  end
endmodule
